//--- hw/uvtp_supervisor.sv
// Undervoltage torque handling, outage hold, overspeed alarm and divided encoder pulse output
//
// How it works
// - Selector 0 ignores sag, 1 warns and limits current, 2 also limits torque internally.
// - Drive-limit mode clamps torque to sag limit, 10..100 percent, default 50.
// - After release, ramp limit back to full over release time, 10..1000 ms.
// - Warn and limit current whenever the DC bus sits below threshold with a nonzero selector.
// - Ride through sags with outage hold time 20..50000 ms, no alarm raised.
// - Overspeed alarm when measured speed exceeds ceiling, 0..65535 rpm, default 10000.
// - Output phases A and B from the encoder, a quarter period apart.
// - Exactly the divided-pulse count per phase per motor revolution.
// - One index pulse on phase C per revolution.
// - Index pulse width equals one phase A pulse width.
// - Reverse direction mode inverts the output phase relationship, so B leads A for forward encoder counts.
// - Stay energised through short outages, drop after hold time, re-energise on return.
// - Outage past hold time drops servo-ready and enters servo-off.
module uvtp_supervisor #(
  parameter int unsigned CYC_PER_MS = uvtp_pkg::CYC_PER_MS
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire uvtp_pkg::uvtp_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  input wire uvtp_pkg::uvtp_pins_t pins,
  output uvtp_pkg::uvtp_pulse_t pulse_out,
  output uvtp_pkg::uvtp_sup_t sup_out
);

  typedef struct packed {
    uvtp_pkg::uvtp_pins_t sync1;
    uvtp_pkg::uvtp_pins_t sync2;
    logic [1:0] enc_prev;
    logic [1:0] uv_sel;
    logic reverse;
    logic servo_off_command;
    logic [6:0] sag_torque_limit;
    logic [9:0] sag_limit_release_time;
    logic [15:0] outage_hold_time;
    logic [15:0] motor_speed_ceiling;
    logic [23:0] divided_pulses_per_rev;
    logic [23:0] encoder_output_resolution;
    logic [31:0] prescale;
    uvtp_pkg::uvtp_uv_state_t uv_state;
    logic [39:0] ramp_acc;
    logic [15:0] outage_ms;
    logic [15:0] speed_cnt;
    logic [15:0] speed_last;
    logic signed [27:0] pulse_acc;
    logic [25:0] out_pos;
    uvtp_pkg::uvtp_pulse_t pulse;
    uvtp_pkg::uvtp_sup_t sup;
    logic [31:0] rdata;
  } uvtp_state_t;

  uvtp_state_t st;
  uvtp_state_t next_st;

  // Combinational helpers
  logic ms_tick;
  logic [1:0] enc_now;
  logic [1:0] enc_diff;
  logic step_up;
  logic step_dn;
  logic signed [27:0] acc_sum;
  logic [27:0] quarter_span;
  logic [25:0] out_last;
  logic [31:0] speed_rpm_x;
  logic [39:0] speed_lim_x;
  logic [39:0] ramp_span;
  logic [6:0] ramp_diff;
  logic power_lost;
  logic uv_detect;
  logic [31:0] status_word;

  // Clamp a written setting into its legal range
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  always_comb begin
    next_st = st;
    // Two-stage synchronisers for all pins
    next_st.sync1 = pins;
    next_st.sync2 = st.sync1;

    // Millisecond timebase
    // Outage and speed logic share this tick so their timing stays aligned; the ramp counts clocks
    ms_tick = (st.prescale == CYC_PER_MS - 1);
    next_st.prescale = ms_tick ? 32'h00000000 : st.prescale + 32'h00000001;

    // Quadrature decode, position index 0..3 along the gray sequence
    enc_now = {st.sync2.enc_a, st.sync2.enc_a ^ st.sync2.enc_b};
    next_st.enc_prev = enc_now;
    enc_diff = enc_now - st.enc_prev;
    // A two-position jump (diff 2) has no known direction, so it is dropped
    // Reverse mode flips count sense, so the output phase order is inverted while the pulse shape stays the same
    step_up = (enc_diff == 2'h1) ^ (st.reverse && enc_diff != 2'h0 && enc_diff != 2'h2);
    step_dn = (enc_diff == 2'h3) ^ (st.reverse && enc_diff != 2'h0 && enc_diff != 2'h2);

    // Fractional divider: each encoder count adds four output quarter-steps per divided pulse
    quarter_span = {2'h0, st.divided_pulses_per_rev, 2'h0};
    out_last = quarter_span[25:0] - 26'h0000001;
    acc_sum = st.pulse_acc;
    if (step_up) begin
      acc_sum = st.pulse_acc + $signed(quarter_span);
    end else if (step_dn) begin
      acc_sum = st.pulse_acc - $signed(quarter_span);
    end
    // One quarter-step per clock; backlog drains on later clocks
    // A smaller pulse count written mid-turn wraps the position at the next upward step
    if (st.encoder_output_resolution != 24'h000000 &&
        acc_sum >= $signed({4'h0, st.encoder_output_resolution})) begin
      next_st.pulse_acc = acc_sum - $signed({4'h0, st.encoder_output_resolution});
      next_st.out_pos = (st.out_pos >= out_last) ? 26'h0000000 : st.out_pos + 26'h0000001;
    end else if (acc_sum < 0) begin
      next_st.pulse_acc = acc_sum + $signed({4'h0, st.encoder_output_resolution});
      next_st.out_pos = (st.out_pos == 26'h0000000) ? out_last : st.out_pos - 26'h0000001;
    end else begin
      next_st.pulse_acc = acc_sum;
    end
    // Quarter-step phase: A high in 1,2 and B high in 2,3, so A leads when counting up
    next_st.pulse.divided_phase_a_out = (next_st.out_pos[1:0] == 2'h1) ||
                                        (next_st.out_pos[1:0] == 2'h2);
    next_st.pulse.divided_phase_b_out = next_st.out_pos[1];
    // Index covers the first phase A high of the revolution
    next_st.pulse.divided_index_out = (next_st.out_pos == 26'h0000001) ||
                                      (next_st.out_pos == 26'h0000002);

    // Speed: encoder counts per ms against ceiling times counts per rev
    if (step_up || step_dn) begin
      next_st.speed_cnt = (st.speed_cnt == 16'hffff) ? st.speed_cnt : st.speed_cnt + 16'h0001;
    end
    speed_rpm_x = st.speed_last * uvtp_pkg::RPM_PER_COUNT_MS;
    speed_lim_x = st.motor_speed_ceiling * st.encoder_output_resolution;
    if (ms_tick) begin
      next_st.speed_last = next_st.speed_cnt;
      next_st.speed_cnt = 16'h0000;
    end

    // Undervoltage detection and torque limit sequencing
    uv_detect = st.sync2.dc_bus_low && (st.uv_sel != uvtp_pkg::UV_OFF);
    next_st.sup.uv_warning = uv_detect;
    next_st.sup.current_limit = uv_detect;
    // Release is one cycle wide, on the same edge the warning falls
    next_st.sup.uv_warning_release = st.sup.uv_warning && !uv_detect;
    ramp_diff = uvtp_pkg::TLIM_FULL - st.sup.torque_limit_pct;
    ramp_span = 40'(st.sag_limit_release_time) * 40'(CYC_PER_MS);
    unique case (st.uv_state)
      uvtp_pkg::UVTP_NORMAL: begin
        next_st.sup.torque_limit_pct = uvtp_pkg::TLIM_FULL;
        next_st.ramp_acc = 40'h0000000000;
        if (uv_detect && st.uv_sel == uvtp_pkg::UV_DRIVE) begin
          next_st.uv_state = uvtp_pkg::UVTP_LIMIT;
        end
      end
      uvtp_pkg::UVTP_LIMIT: begin
        next_st.sup.torque_limit_pct = st.sag_torque_limit;
        next_st.ramp_acc = 40'h0000000000;
        if (!uv_detect) begin
          next_st.uv_state = uvtp_pkg::UVTP_RAMP;
        end
      end
      uvtp_pkg::UVTP_RAMP: begin
        // Bresenham ramp: rise of (100 - sag) spread evenly across the release time
        next_st.ramp_acc = st.ramp_acc + 40'(uvtp_pkg::TLIM_FULL - st.sag_torque_limit);
        if (next_st.ramp_acc >= ramp_span) begin
          next_st.ramp_acc = next_st.ramp_acc - ramp_span;
          if (ramp_diff != 7'h00) begin
            next_st.sup.torque_limit_pct = st.sup.torque_limit_pct + 7'h01;
          end
        end
        if (uv_detect) begin
          next_st.uv_state = uvtp_pkg::UVTP_LIMIT;
        end else if (st.sup.torque_limit_pct >= uvtp_pkg::TLIM_FULL ||
                     st.uv_sel != uvtp_pkg::UV_DRIVE) begin
          next_st.uv_state = uvtp_pkg::UVTP_NORMAL;
        end
      end
    endcase
    // Leaving drive mode while limited snaps straight back to full torque
    if (st.uv_sel != uvtp_pkg::UV_DRIVE && st.uv_state == uvtp_pkg::UVTP_LIMIT) begin
      next_st.uv_state = uvtp_pkg::UVTP_NORMAL;
    end

    // Outage hold: ride through short loss, drop ready once the hold time is passed
    // Limitation: one ms granularity, so ready may drop up to one tick early
    power_lost = !st.sync2.main_power_ok;
    if (!power_lost) begin
      next_st.outage_ms = 16'h0000;
    end else if (ms_tick && st.outage_ms != 16'hffff) begin
      next_st.outage_ms = st.outage_ms + 16'h0001;
    end
    // Undervoltage alone never touches ready, so a sag raises no alarm
    next_st.sup.servo_ready = !(power_lost && st.outage_ms >= st.outage_hold_time);
    next_st.sup.motor_energise = next_st.sup.servo_ready && !st.servo_off_command;

    // Register write; hardware set of the overspeed alarm wins over a clear
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        uvtp_pkg::OFS_CTRL: begin
          next_st.uv_sel = bus_req.wdata[uvtp_pkg::CTRL_SEL_LSB +: 2];
          next_st.reverse = bus_req.wdata[uvtp_pkg::CTRL_REVERSE];
          next_st.servo_off_command = bus_req.wdata[uvtp_pkg::CTRL_SERVO_OFF];
        end
        uvtp_pkg::OFS_SAG_LIMIT: begin
          // Clamp on the low 16 bits, so an oversized write up to 65535 saturates instead of wrapping
          next_st.sag_torque_limit = 7'(clamp16(bus_req.wdata[15:0],
              {9'h000, uvtp_pkg::SAG_MIN}, {9'h000, uvtp_pkg::SAG_MAX}));
        end
        uvtp_pkg::OFS_RELEASE_TIME: begin
          // Same wide clamp for the release time
          next_st.sag_limit_release_time = 10'(clamp16(bus_req.wdata[15:0],
              {6'h00, uvtp_pkg::REL_MIN}, {6'h00, uvtp_pkg::REL_MAX}));
        end
        uvtp_pkg::OFS_HOLD_TIME: begin
          next_st.outage_hold_time = clamp16(bus_req.wdata[15:0], uvtp_pkg::HOLD_MIN,
              uvtp_pkg::HOLD_MAX);
        end
        uvtp_pkg::OFS_SPEED_CEIL: begin
          next_st.motor_speed_ceiling = bus_req.wdata[15:0];
        end
        uvtp_pkg::OFS_DIV_PULSES: begin
          next_st.divided_pulses_per_rev = (bus_req.wdata[23:0] < uvtp_pkg::DIV_MIN) ?
              uvtp_pkg::DIV_MIN : bus_req.wdata[23:0];
        end
        uvtp_pkg::OFS_ENC_RES: begin
          next_st.encoder_output_resolution = bus_req.wdata[23:0];
        end
        uvtp_pkg::OFS_STATUS: begin
          if (bus_req.wdata[uvtp_pkg::ST_OVERSPEED]) begin
            next_st.sup.overspeed_alarm = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Speed refreshes once per ms, so the alarm trails a real overspeed by up to 2 ms
    if ({8'h00, speed_rpm_x} > speed_lim_x) begin
      next_st.sup.overspeed_alarm = 1'b1;
    end

    // Register read, data one cycle after the strobe; unmapped reads return zero
    status_word = 32'h00000000;
    status_word[uvtp_pkg::ST_WARN] = st.sup.uv_warning;
    status_word[uvtp_pkg::ST_OVERSPEED] = st.sup.overspeed_alarm;
    status_word[uvtp_pkg::ST_READY] = st.sup.servo_ready;
    status_word[uvtp_pkg::ST_ENERGISED] = st.sup.motor_energise;
    status_word[uvtp_pkg::ST_TLIM_LSB +: 7] = st.sup.torque_limit_pct;
    next_st.rdata = 32'h00000000;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        uvtp_pkg::OFS_CTRL: next_st.rdata = {28'h0000000, st.servo_off_command, st.reverse,
                                             st.uv_sel};
        uvtp_pkg::OFS_SAG_LIMIT: next_st.rdata = {25'h0000000, st.sag_torque_limit};
        uvtp_pkg::OFS_RELEASE_TIME: next_st.rdata = {22'h000000, st.sag_limit_release_time};
        uvtp_pkg::OFS_HOLD_TIME: next_st.rdata = {16'h0000, st.outage_hold_time};
        uvtp_pkg::OFS_SPEED_CEIL: next_st.rdata = {16'h0000, st.motor_speed_ceiling};
        uvtp_pkg::OFS_DIV_PULSES: next_st.rdata = {8'h00, st.divided_pulses_per_rev};
        uvtp_pkg::OFS_ENC_RES: next_st.rdata = {8'h00, st.encoder_output_resolution};
        uvtp_pkg::OFS_STATUS: next_st.rdata = status_word;
        uvtp_pkg::OFS_SPEED: next_st.rdata = {16'h0000, st.speed_last};
        default: next_st.rdata = 32'h00000000;
      endcase
    end
  end

  // State register; reset gives full torque, ready asserted on the first clock after reset
  // Power pins reset to the good level so no false outage follows reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.sync1.main_power_ok <= 1'b1;
      st.sync2.main_power_ok <= 1'b1;
      st.sag_torque_limit <= uvtp_pkg::SAG_RST;
      st.sag_limit_release_time <= uvtp_pkg::REL_RST;
      st.outage_hold_time <= uvtp_pkg::HOLD_RST;
      st.motor_speed_ceiling <= uvtp_pkg::CEIL_RST;
      st.divided_pulses_per_rev <= uvtp_pkg::DIV_RST;
      st.encoder_output_resolution <= uvtp_pkg::RES_RST;
      st.uv_state <= uvtp_pkg::UVTP_NORMAL;
      st.sup.torque_limit_pct <= uvtp_pkg::TLIM_FULL;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign bus_rdata = st.rdata;
  assign pulse_out = st.pulse;
  assign sup_out = st.sup;

endmodule

//--- hw/uvtp_pkg.sv
// Shared constants and carrier types for the undervoltage, speed and pulse-out block
package uvtp_pkg;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned RPM_PER_COUNT_MS = 60000;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SAG_LIMIT = 8'h04;
  localparam logic [7:0] OFS_RELEASE_TIME = 8'h08;
  localparam logic [7:0] OFS_HOLD_TIME = 8'h0c;
  localparam logic [7:0] OFS_SPEED_CEIL = 8'h10;
  localparam logic [7:0] OFS_DIV_PULSES = 8'h14;
  localparam logic [7:0] OFS_ENC_RES = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_SPEED = 8'h20;
  // Control field positions
  localparam int unsigned CTRL_SEL_LSB = 0;
  localparam int unsigned CTRL_REVERSE = 2;
  localparam int unsigned CTRL_SERVO_OFF = 3;
  // Status field positions
  localparam int unsigned ST_WARN = 0;
  localparam int unsigned ST_OVERSPEED = 1;
  localparam int unsigned ST_READY = 2;
  localparam int unsigned ST_ENERGISED = 3;
  localparam int unsigned ST_TLIM_LSB = 8;
  // Undervoltage selector values
  localparam logic [1:0] UV_OFF = 2'h0;
  localparam logic [1:0] UV_HOST = 2'h1;
  localparam logic [1:0] UV_DRIVE = 2'h2;
  // Ranges and reset values
  localparam logic [6:0] SAG_MIN = 7'h0a;
  localparam logic [6:0] SAG_MAX = 7'h64;
  localparam logic [6:0] SAG_RST = 7'h32;
  localparam logic [9:0] REL_MIN = 10'h00a;
  localparam logic [9:0] REL_MAX = 10'h3e8;
  localparam logic [9:0] REL_RST = 10'h064;
  localparam logic [15:0] HOLD_MIN = 16'h0014;
  localparam logic [15:0] HOLD_MAX = 16'hc350;
  localparam logic [15:0] HOLD_RST = 16'h0014;
  localparam logic [15:0] CEIL_RST = 16'h2710;
  localparam logic [23:0] DIV_MIN = 24'h000010;
  localparam logic [23:0] DIV_RST = 24'h0009c4;
  localparam logic [23:0] RES_RST = 24'h002710;
  localparam logic [6:0] TLIM_FULL = 7'h64;

  typedef enum logic [1:0] {UVTP_NORMAL, UVTP_LIMIT, UVTP_RAMP} uvtp_uv_state_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } uvtp_bus_req_t;

  // Pins from outside the clock domain
  typedef struct packed {
    logic enc_a;
    logic enc_b;
    logic dc_bus_low;
    logic main_power_ok;
  } uvtp_pins_t;

  // Divided pulse outputs
  typedef struct packed {
    logic divided_phase_a_out;
    logic divided_phase_b_out;
    logic divided_index_out;
  } uvtp_pulse_t;

  // Supervision outputs
  typedef struct packed {
    logic uv_warning;
    logic uv_warning_release;
    logic current_limit;
    logic [6:0] torque_limit_pct;
    logic overspeed_alarm;
    logic servo_ready;
    logic motor_energise;
  } uvtp_sup_t;
endpackage

//--- verification/uvtp_supervisor_properties.sv
// Port-level checks bound onto the supervisor block
module uvtp_sup_checker (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire uvtp_pkg::uvtp_bus_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  input wire uvtp_pkg::uvtp_pins_t pins,
  input wire uvtp_pkg::uvtp_pulse_t pulse_out,
  input wire uvtp_pkg::uvtp_sup_t sup_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Current limit follows the warning
  property p_cur_lim;
    sup_out.current_limit == sup_out.uv_warning;
  endproperty
  a_cur_lim: assert property (p_cur_lim) else $error("current limit apart from warning");
  // Two sync stages before warning can move
  property p_warn_rise;
    $rose(sup_out.uv_warning) |-> $past(pins.dc_bus_low, 2);
  endproperty
  a_warn_rise: assert property (p_warn_rise) else $error("warning without low bus");
  property p_warn_fall;
    $fell(sup_out.uv_warning) |-> !$past(pins.dc_bus_low, 2);
  endproperty
  a_warn_fall: assert property (p_warn_fall) else $error("warning cleared on low bus");
  property p_release;
    $fell(sup_out.uv_warning) |-> ##[0:1] sup_out.uv_warning_release;
  endproperty
  a_release: assert property (p_release) else $error("no release pulse");
  property p_release_pulse;
    sup_out.uv_warning_release |=> !sup_out.uv_warning_release;
  endproperty
  a_release_pulse: assert property (p_release_pulse) else $error("release too long");
  property p_tlim_range;
    sup_out.torque_limit_pct >= 7'h0a && sup_out.torque_limit_pct <= 7'h64;
  endproperty
  a_tlim_range: assert property (p_tlim_range) else $error("torque limit out of range");
  // Ramp back climbs one percent at a time
  property p_tlim_step;
    sup_out.torque_limit_pct > $past(sup_out.torque_limit_pct) |->
      sup_out.torque_limit_pct == $past(sup_out.torque_limit_pct) + 7'h01;
  endproperty
  a_tlim_step: assert property (p_tlim_step) else $error("torque ramp jumped");
  property p_quad;
    $changed(pulse_out.divided_phase_a_out) |-> $stable(pulse_out.divided_phase_b_out);
  endproperty
  a_quad: assert property (p_quad) else $error("both phases moved together");
  property p_index_a;
    pulse_out.divided_index_out |-> pulse_out.divided_phase_a_out;
  endproperty
  a_index_a: assert property (p_index_a) else $error("index outside phase a high");
  property p_index_edge;
    $changed(pulse_out.divided_index_out) |-> $changed(pulse_out.divided_phase_a_out);
  endproperty
  a_index_edge: assert property (p_index_edge) else $error("index width off phase a");
  property p_energise;
    sup_out.motor_energise |-> sup_out.servo_ready;
  endproperty
  a_energise: assert property (p_energise) else $error("energised while not ready");
  // Alarm is sticky: only a one written to its status bit drops it
  property p_ovs_clear;
    $fell(sup_out.overspeed_alarm) |-> $past(bus_req.wr) && $past(bus_req.wdata[1])
      && $past(bus_req.addr) == uvtp_pkg::OFS_STATUS;
  endproperty
  a_ovs_clear: assert property (p_ovs_clear) else $error("overspeed dropped alone");
endmodule

bind uvtp_supervisor uvtp_sup_checker i_uvtp_sup_checker (.ref_clk(ref_clk), .resetn(resetn),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .pins(pins), .pulse_out(pulse_out), .sup_out(sup_out));

//--- verification/uvtp_host_model.sv
// Host controller model: decodes divided pulses, follows sag warnings
module uvtp_host_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire uvtp_pkg::uvtp_pulse_t pulse_out,
  input wire uvtp_pkg::uvtp_sup_t sup_out,
  output logic signed [15:0] host_pos,
  output logic [15:0] a_rise_count,
  output logic [15:0] index_count,
  output logic host_tlim
);
  logic [1:0] prev_ab;
  logic prev_c;
  logic [1:0] cur_ab;
  assign cur_ab = {pulse_out.divided_phase_a_out, pulse_out.divided_phase_b_out};
  // Edge order gives direction; a bad jump is simply not counted
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {prev_ab, prev_c, host_pos, a_rise_count, index_count, host_tlim} <= '0;
    end else begin
      prev_ab <= cur_ab;
      prev_c <= pulse_out.divided_index_out;
      if (cur_ab == {~prev_ab[0], prev_ab[1]}) begin
        host_pos <= host_pos + 16'sh0001;
      end else if (cur_ab == {prev_ab[0], ~prev_ab[1]}) begin
        host_pos <= host_pos - 16'sh0001;
      end
      if (cur_ab[1] && !prev_ab[1]) begin
        a_rise_count <= a_rise_count + 16'h0001;
      end
      if (pulse_out.divided_index_out && !prev_c) begin
        index_count <= index_count + 16'h0001;
      end
      // Host-side torque limit held from warning to release
      if (sup_out.uv_warning) begin
        host_tlim <= 1'b1;
      end else if (sup_out.uv_warning_release) begin
        host_tlim <= 1'b0;
      end
    end
  end
endmodule

//--- verification/uvtp_supervisor_tb_top.sv
// Self-checking bench for the supervisor block
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: got %0h exp %0h", $time, a, b); end end
module uvtp_supervisor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned MS = 20; // Shortened ms so ramps and holds stay brief
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  uvtp_pkg::uvtp_bus_req_t bus_req = '0;
  uvtp_pkg::uvtp_pins_t pins = 4'h1;
  logic [31:0] bus_rdata;
  uvtp_pkg::uvtp_pulse_t pulse_out;
  uvtp_pkg::uvtp_sup_t sup_out;
  logic signed [15:0] host_pos;
  logic [15:0] a_rise_count;
  logic [15:0] index_count;
  logic host_tlim;
  logic [6:0] sag;
  logic [31:0] rd_val;
  int err_count = 0;
  int check_count = 0;
  int seed = 42;
  int enc_q = 0;
  logic [31:0] rtab [9][2] = '{'{32'h00, 32'h0}, '{32'h04, 32'h32}, '{32'h08, 32'h64},
    '{32'h0c, 32'h14}, '{32'h10, 32'h2710}, '{32'h14, 32'h9c4}, '{32'h18, 32'h2710},
    '{32'h1c, 32'h640c}, '{32'h24, 32'h0}};
  logic [31:0] ctab [6][4] = '{'{32'h04, 32'h05, 32'h0a, 32'h64},
    '{32'h04, 32'h78, 32'h0a, 32'h64}, '{32'h08, 32'h7d0, 32'h0a, 32'h3e8},
    '{32'h0c, 32'h3e8, 32'h14, 32'hc350},
    '{32'h0c, 32'h0a, 32'h14, 32'hc350}, '{32'h14, 32'h03, 32'h10, 32'hffffff}};

  always #2.5 ref_clk = ~ref_clk;

  uvtp_supervisor #(.CYC_PER_MS(MS)) i_uvtp_supervisor (.ref_clk(ref_clk), .resetn(resetn),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .pins(pins), .pulse_out(pulse_out),
    .sup_out(sup_out));
  uvtp_host_model i_uvtp_host_model (.ref_clk(ref_clk), .resetn(resetn), .pulse_out(pulse_out),
    .sup_out(sup_out), .host_pos(host_pos), .a_rise_count(a_rise_count),
    .index_count(index_count), .host_tlim(host_tlim));

  function automatic logic [31:0] clamp(input logic [31:0] v, lo, hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
  function automatic logic [6:0] exp_tlim(input int sel, input logic [6:0] s);
    return (sel == 2) ? s : 7'h64;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Bus cycles: one-cycle strobes, read data one cycle later
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk) bus_req.wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a);
    @(posedge ref_clk) bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk) bus_req.rd <= 1'b0;
    #1 rd_val = bus_rdata;
  endtask
  // Gray-coded encoder, B leads for positive counts; four clocks per count for the synchroniser
  task automatic enc_step(input int n);
    repeat ((n < 0) ? -n : n) begin
      enc_q = (n > 0) ? (enc_q + 1) % 4 : (enc_q + 3) % 4;
      repeat (4) @(posedge ref_clk);
      pins.enc_a <= enc_q inside {2, 3};
      pins.enc_b <= enc_q inside {1, 2};
    end
    repeat (8) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_release();
    int i;
    for (i = 0; i < 12 && sup_out.uv_warning_release !== 1'b1; i++) @(posedge ref_clk) #1;
    if (i == 12) begin
      err_count++;
      report_and_stop();
    end
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    bus_wr(8'h24, 32'hffffffff);
    foreach (rtab[i]) begin
      bus_rd(rtab[i][0][7:0]);
      `CHK(rd_val, rtab[i][1])
    end
    // Out-of-range settings are clamped into their ranges
    foreach (ctab[i]) begin
      bus_wr(ctab[i][0][7:0], ctab[i][1]);
      bus_rd(ctab[i][0][7:0]);
      `CHK(rd_val, clamp(ctab[i][1], ctab[i][2], ctab[i][3]))
    end
    // Selector values 0, 1 and 2, each against a sag with a random limit
    for (int sel = 0; sel < 3; sel++) begin
      sag = 7'(10 + ($unsigned($random(seed)) % 91));
      bus_wr(8'h04, {25'h0, sag});
      bus_wr(8'h08, 32'h0a);
      bus_wr(8'h00, 32'(sel));
      @(posedge ref_clk) pins.dc_bus_low <= 1'b1;
      repeat (10) @(posedge ref_clk);
      #1;
      `CHK(sup_out.uv_warning, sel != 0)
      `CHK(sup_out.torque_limit_pct, exp_tlim(sel, sag))
      `CHK(host_tlim, sel != 0)
      `CHK(sup_out.servo_ready, 1'b1)
      @(posedge ref_clk) pins.dc_bus_low <= 1'b0;
      if (sel != 0) begin
        wait_release();
      end
      repeat (5 * MS) @(posedge ref_clk);
      #1;
      `CHK(sup_out.torque_limit_pct < 7'h64, sel == 2 && sag < 7'h64)
      `CHK(host_tlim, 1'b0)
      repeat (6 * MS) @(posedge ref_clk);
      #1;
      `CHK(sup_out.torque_limit_pct, 7'h64)
    end
    // Sixteen pulses per turn from 64 decoded counts, two turns each way
    bus_wr(8'h14, 32'h10);
    bus_wr(8'h18, 32'h40);
    enc_step(128);
    `CHK({host_pos, a_rise_count, index_count}, {16'sh0080, 16'h20, 16'h2})
    `CHK(sup_out.overspeed_alarm, 1'b0)
    enc_step(-128);
    `CHK({host_pos, a_rise_count, index_count}, {16'sh0000, 16'h40, 16'h4})
    bus_wr(8'h00, 32'h4);
    enc_step(64);
    `CHK(host_pos, -16'sh0040)
    `CHK({a_rise_count, index_count}, {16'h50, 16'h5})
    // Lower ceiling trips the alarm, which sticks until cleared
    bus_wr(8'h10, 32'hfa0);
    enc_step(16);
    repeat (3 * MS) @(posedge ref_clk);
    bus_rd(8'h1c);
    `CHK(rd_val[1], 1'b1)
    bus_wr(8'h1c, 32'h2);
    #1;
    `CHK(sup_out.overspeed_alarm, 1'b0)
    // Short and long outages, then servo off on command
    for (int ms = 5; ms < 30; ms += 20) begin
      @(posedge ref_clk) pins.main_power_ok <= 1'b0;
      repeat (ms * MS) @(posedge ref_clk);
      #1;
      `CHK({sup_out.servo_ready, sup_out.motor_energise}, {2{ms < 20}})
      @(posedge ref_clk) pins.main_power_ok <= 1'b1;
      repeat (6) @(posedge ref_clk);
      #1;
      `CHK({sup_out.servo_ready, sup_out.motor_energise}, 2'h3)
    end
    bus_wr(8'h00, 32'h8);
    @(posedge ref_clk) #1;
    `CHK({sup_out.servo_ready, sup_out.motor_energise}, 2'h2)
    report_and_stop();
  end
endmodule
